// File: bprs_pkg.sv
package bprs_pkg;

    // time base
    localparam int CLK_HZ = 10_000_000;
    localparam int T10_MS = 10;
    localparam int T5_MS = 5;
    localparam int T1_MS = 1;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int CYC_10MS = T10_MS * CYC_PER_MS;
    localparam int CYC_5MS = T5_MS * CYC_PER_MS;
    localparam int CYC_1MS = T1_MS * CYC_PER_MS;
    localparam int CNT_W = 20;

    // power-good inputs
    typedef struct packed {
        logic payload_12v_rail;
        logic aux_3v3_rail;
        logic mezz_5v_rail;
        logic rail_2v5;
        logic avs_core_rail;
        logic fixed_core_rail;
        logic io_1v8_rail;
        logic ddr_1v5_rail;
        logic ddr_term_0v75_rail;
        logic pll_lock;
    } bprs_pg_t;

    // rail enables
    typedef struct packed {
        logic mezz_5v_rail;
        logic rail_2v5;
        logic avs_core_rail;
        logic fixed_core_rail;
        logic io_1v8_rail;
        logic ddr_1v5_rail;
        logic ddr_term_0v75_rail;
    } bprs_en_t;

    // processor facing outputs
    typedef struct packed {
        logic out_1v8_unlock;
        logic clkgen_power_down_n;
        logic mux_power_down_n;
        logic mux_output_enable;
        logic warm_reset_n;
        logic other_unlock;
        logic power_on_reset_n;
        logic full_reset_n;
        logic boot_drive;
    } bprs_cpu_t;

    typedef enum logic [3:0] {
        ST_OFF = 4'h0,
        ST_AUX = 4'h1,
        ST_MID = 4'h3,
        ST_CORE = 4'h2,
        ST_FIX = 4'h6,
        ST_IO = 4'h7,
        ST_CLK = 4'h5,
        ST_DDR = 4'h4,
        ST_TERM = 4'hc,
        ST_WARM = 4'hd,
        ST_POR = 4'hf,
        ST_FULL = 4'he,
        ST_RUN = 4'ha,
        ST_DN1 = 4'hb,
        ST_DN2 = 4'h9
    } bprs_state_t;

    localparam bprs_en_t EN_RST = '0;
    localparam bprs_cpu_t CPU_RST = '0;

endpackage : bprs_pkg

// File: bprs_top.sv
// What this block does
// - after payload and aux power, hold every processor-facing output low until unlocked
// - enable 5V and 2.5V rails after aux 3.3V stable 10ms
// - enable avs core rail after 5V and 2.5V both stable 5ms
// - enable io 1.8V rail after fixed core rail stable 5ms
// - after io 1.8V stable 5ms unlock 1.8V outputs, release clock generator
// - enable ddr 1.5V rail 5ms after clock generator start
// - enable ddr termination rail after ddr 1.5V stable 5ms
// - release mux power-down when ddr 1.5V reports valid
// - assert mux output enable when ddr termination reports valid
// - release warm reset, unlock other resets after term rail and pll 5ms
// - drive boot configuration pins from warm reset release onward
// - release power-on reset 5ms after warm reset release
// - release full reset 5ms after power-on reset release
// - release boot pins 1ms after full reset release
// - on power failure assert full and power-on resets at once
// - 5ms later lock 1.8V outputs and stop clock generator
// - then remove all main rail enables and mux controls at once
// - system power good only while all supervised supplies are valid
module bprs_top #(
    parameter int CYC_10MS = bprs_pkg::CYC_10MS,
    parameter int CYC_5MS = bprs_pkg::CYC_5MS,
    parameter int CYC_1MS = bprs_pkg::CYC_1MS,
    parameter int BOOT_W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // power-good and pll lock inputs from pins
    input wire bprs_pkg::bprs_pg_t pg_in,
    // boot configuration selection
    input wire logic [BOOT_W-1:0] boot_cfg_in,
    // regulator enables
    output bprs_pkg::bprs_en_t rail_en,
    // processor, clock generator and mux controls
    output bprs_pkg::bprs_cpu_t cpu_out,
    // boot pins: value and output enable (low = driving)
    output logic [BOOT_W-1:0] boot_pin_out,
    output logic boot_pin_oe_n,
    // system status
    output logic system_power_good
);

    typedef struct packed {
        bprs_pkg::bprs_pg_t pg_s1;
        bprs_pkg::bprs_pg_t pg_s2;
        logic [BOOT_W-1:0] boot_s1;
        logic [BOOT_W-1:0] boot_s2;
        bprs_pkg::bprs_state_t st;
        logic [bprs_pkg::CNT_W-1:0] cnt;
        bprs_pkg::bprs_en_t en;
        bprs_pkg::bprs_cpu_t cpu;
        logic [BOOT_W-1:0] boot;
        logic boot_oe_n;
        logic pgood;
    } bprs_st_t;

    localparam logic [bprs_pkg::CNT_W-1:0] C10 = bprs_pkg::CNT_W'(CYC_10MS - 1);
    localparam logic [bprs_pkg::CNT_W-1:0] C5 = bprs_pkg::CNT_W'(CYC_5MS - 1);
    localparam logic [bprs_pkg::CNT_W-1:0] C1 = bprs_pkg::CNT_W'(CYC_1MS - 1);

    bprs_st_t s_r;
    bprs_st_t s_nxt;
    logic rst_s1_r;
    logic rst_s2_r;

    ////////////////////////////////////////////////////////////////////////
    // reset release
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counts a condition held for lim+1 cycles; restarts when it drops
    function automatic logic [bprs_pkg::CNT_W:0] stable(
        input logic cond,
        input logic [bprs_pkg::CNT_W-1:0] cnt,
        input logic [bprs_pkg::CNT_W-1:0] lim
    );
        logic [bprs_pkg::CNT_W:0] r;
        r = '0;
        if (!cond) begin
            r = '0;
        end else if (cnt >= lim) begin
            r = {1'b1, bprs_pkg::CNT_W'(0)};
        end else begin
            r = {1'b0, cnt + bprs_pkg::CNT_W'(1)};
        end
        return r;
    endfunction : stable

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    logic [bprs_pkg::CNT_W:0] t;
    logic fail;
    bprs_pkg::bprs_pg_t pg;

    always_comb begin
        s_nxt = s_r;
        s_nxt.pg_s1 = pg_in;
        s_nxt.pg_s2 = s_r.pg_s1;
        s_nxt.boot_s1 = boot_cfg_in;
        s_nxt.boot_s2 = s_r.boot_s1;
        pg = s_r.pg_s2;
        t = '0;
        // loss of payload/aux, or of any enabled rail once its own stability wait has passed
        fail = !pg.payload_12v_rail || !pg.aux_3v3_rail;
        if (s_r.st inside {bprs_pkg::ST_CORE, bprs_pkg::ST_FIX, bprs_pkg::ST_IO,
                bprs_pkg::ST_CLK, bprs_pkg::ST_DDR, bprs_pkg::ST_TERM,
                bprs_pkg::ST_WARM, bprs_pkg::ST_POR, bprs_pkg::ST_FULL,
                bprs_pkg::ST_RUN}) begin
            if (!pg.mezz_5v_rail || !pg.rail_2v5) begin
                fail = 1'b1;
            end
        end
        if (s_r.st inside {bprs_pkg::ST_IO, bprs_pkg::ST_CLK, bprs_pkg::ST_DDR,
                bprs_pkg::ST_TERM, bprs_pkg::ST_WARM, bprs_pkg::ST_POR,
                bprs_pkg::ST_FULL, bprs_pkg::ST_RUN}) begin
            if (!pg.avs_core_rail || !pg.fixed_core_rail) begin
                fail = 1'b1;
            end
        end
        if (s_r.st inside {bprs_pkg::ST_CLK, bprs_pkg::ST_DDR, bprs_pkg::ST_TERM,
                bprs_pkg::ST_WARM, bprs_pkg::ST_POR, bprs_pkg::ST_FULL,
                bprs_pkg::ST_RUN}) begin
            if (!pg.io_1v8_rail) begin
                fail = 1'b1;
            end
        end
        if (s_r.st inside {bprs_pkg::ST_TERM, bprs_pkg::ST_WARM, bprs_pkg::ST_POR,
                bprs_pkg::ST_FULL, bprs_pkg::ST_RUN}) begin
            if (!pg.ddr_1v5_rail) begin
                fail = 1'b1;
            end
        end
        if (s_r.st inside {bprs_pkg::ST_WARM, bprs_pkg::ST_POR,
                bprs_pkg::ST_FULL, bprs_pkg::ST_RUN}) begin
            if (!pg.ddr_term_0v75_rail) begin
                fail = 1'b1;
            end
        end

        case (s_r.st)
            bprs_pkg::ST_OFF: begin
                s_nxt.en = bprs_pkg::EN_RST;
                s_nxt.cpu = bprs_pkg::CPU_RST;
                s_nxt.cnt = '0;
                if (pg.payload_12v_rail) begin
                    s_nxt.st = bprs_pkg::ST_AUX;
                end
            end
            bprs_pkg::ST_AUX: begin
                t = stable(pg.aux_3v3_rail, s_r.cnt, C10);
                s_nxt.cnt = t[bprs_pkg::CNT_W-1:0];
                if (!pg.payload_12v_rail) begin
                    s_nxt.st = bprs_pkg::ST_OFF;
                end else if (t[bprs_pkg::CNT_W]) begin
                    s_nxt.en.mezz_5v_rail = 1'b1;
                    s_nxt.en.rail_2v5 = 1'b1;
                    s_nxt.st = bprs_pkg::ST_MID;
                end
            end
            bprs_pkg::ST_MID: begin
                t = stable(pg.mezz_5v_rail && pg.rail_2v5, s_r.cnt, C5);
                s_nxt.cnt = t[bprs_pkg::CNT_W-1:0];
                if (t[bprs_pkg::CNT_W]) begin
                    s_nxt.en.avs_core_rail = 1'b1;
                    // the controller delays its second output itself
                    s_nxt.en.fixed_core_rail = 1'b1;
                    s_nxt.st = bprs_pkg::ST_CORE;
                end
            end
            bprs_pkg::ST_CORE: begin
                s_nxt.cnt = '0;
                if (pg.avs_core_rail) begin
                    s_nxt.st = bprs_pkg::ST_FIX;
                end
            end
            bprs_pkg::ST_FIX: begin
                t = stable(pg.fixed_core_rail && pg.avs_core_rail, s_r.cnt, C5);
                s_nxt.cnt = t[bprs_pkg::CNT_W-1:0];
                if (t[bprs_pkg::CNT_W]) begin
                    s_nxt.en.io_1v8_rail = 1'b1;
                    s_nxt.st = bprs_pkg::ST_IO;
                end
            end
            bprs_pkg::ST_IO: begin
                t = stable(pg.io_1v8_rail, s_r.cnt, C5);
                s_nxt.cnt = t[bprs_pkg::CNT_W-1:0];
                if (t[bprs_pkg::CNT_W]) begin
                    s_nxt.cpu.out_1v8_unlock = 1'b1;
                    s_nxt.cpu.clkgen_power_down_n = 1'b1;
                    s_nxt.st = bprs_pkg::ST_CLK;
                end
            end
            bprs_pkg::ST_CLK: begin
                t = stable(1'b1, s_r.cnt, C5);
                s_nxt.cnt = t[bprs_pkg::CNT_W-1:0];
                if (t[bprs_pkg::CNT_W]) begin
                    s_nxt.en.ddr_1v5_rail = 1'b1;
                    s_nxt.st = bprs_pkg::ST_DDR;
                end
            end
            bprs_pkg::ST_DDR: begin
                s_nxt.cpu.mux_power_down_n = pg.ddr_1v5_rail;
                t = stable(pg.ddr_1v5_rail, s_r.cnt, C5);
                s_nxt.cnt = t[bprs_pkg::CNT_W-1:0];
                if (t[bprs_pkg::CNT_W]) begin
                    s_nxt.en.ddr_term_0v75_rail = 1'b1;
                    s_nxt.st = bprs_pkg::ST_TERM;
                end
            end
            bprs_pkg::ST_TERM: begin
                s_nxt.cpu.mux_output_enable = pg.ddr_term_0v75_rail;
                t = stable(pg.ddr_term_0v75_rail && pg.pll_lock, s_r.cnt, C5);
                s_nxt.cnt = t[bprs_pkg::CNT_W-1:0];
                if (t[bprs_pkg::CNT_W]) begin
                    s_nxt.cpu.warm_reset_n = 1'b1;
                    s_nxt.cpu.other_unlock = 1'b1;
                    s_nxt.cpu.boot_drive = 1'b1;
                    s_nxt.boot = s_r.boot_s2;
                    s_nxt.st = bprs_pkg::ST_WARM;
                end
            end
            bprs_pkg::ST_WARM: begin
                t = stable(1'b1, s_r.cnt, C5);
                s_nxt.cnt = t[bprs_pkg::CNT_W-1:0];
                if (t[bprs_pkg::CNT_W]) begin
                    s_nxt.cpu.power_on_reset_n = 1'b1;
                    s_nxt.st = bprs_pkg::ST_POR;
                end
            end
            bprs_pkg::ST_POR: begin
                t = stable(1'b1, s_r.cnt, C5);
                s_nxt.cnt = t[bprs_pkg::CNT_W-1:0];
                if (t[bprs_pkg::CNT_W]) begin
                    s_nxt.cpu.full_reset_n = 1'b1;
                    s_nxt.st = bprs_pkg::ST_FULL;
                end
            end
            bprs_pkg::ST_FULL: begin
                t = stable(1'b1, s_r.cnt, C1);
                s_nxt.cnt = t[bprs_pkg::CNT_W-1:0];
                if (t[bprs_pkg::CNT_W]) begin
                    s_nxt.cpu.boot_drive = 1'b0;
                    s_nxt.boot = '0;
                    s_nxt.st = bprs_pkg::ST_RUN;
                end
            end
            bprs_pkg::ST_RUN: begin
                s_nxt.cnt = '0;
            end
            bprs_pkg::ST_DN1: begin
                t = stable(1'b1, s_r.cnt, C5);
                s_nxt.cnt = t[bprs_pkg::CNT_W-1:0];
                if (t[bprs_pkg::CNT_W]) begin
                    s_nxt.cpu.out_1v8_unlock = 1'b0;
                    s_nxt.cpu.clkgen_power_down_n = 1'b0;
                    s_nxt.cpu.other_unlock = 1'b0;
                    s_nxt.cpu.warm_reset_n = 1'b0;
                    s_nxt.st = bprs_pkg::ST_DN2;
                end
            end
            bprs_pkg::ST_DN2: begin
                s_nxt.en = bprs_pkg::EN_RST;
                s_nxt.cpu.mux_power_down_n = 1'b0;
                s_nxt.cpu.mux_output_enable = 1'b0;
                s_nxt.cnt = '0;
                s_nxt.st = bprs_pkg::ST_OFF;
            end
            default: begin
                s_nxt.st = bprs_pkg::ST_OFF;
            end
        endcase

        if (fail && !(s_r.st inside {bprs_pkg::ST_OFF, bprs_pkg::ST_AUX,
                bprs_pkg::ST_DN1, bprs_pkg::ST_DN2})) begin
            s_nxt.cpu.full_reset_n = 1'b0;
            s_nxt.cpu.power_on_reset_n = 1'b0;
            s_nxt.cpu.boot_drive = 1'b0;
            s_nxt.boot = '0;
            s_nxt.cnt = '0;
            s_nxt.st = bprs_pkg::ST_DN1;
        end

        // registered copy so the pin enable comes straight from a flop
        s_nxt.boot_oe_n = !s_nxt.cpu.boot_drive;
        s_nxt.pgood = pg.payload_12v_rail && pg.aux_3v3_rail && pg.mezz_5v_rail
            && pg.rail_2v5 && pg.avs_core_rail && pg.fixed_core_rail
            && pg.io_1v8_rail && pg.ddr_1v5_rail && pg.ddr_term_0v75_rail
            && (s_r.st == bprs_pkg::ST_RUN);
    end

    always_ff @(posedge ref_clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            s_r <= '0;
            // boot pins released while in reset
            s_r.boot_oe_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign rail_en = s_r.en;
    assign cpu_out = s_r.cpu;
    assign boot_pin_out = s_r.boot;
    assign boot_pin_oe_n = s_r.boot_oe_n;
    assign system_power_good = s_r.pgood;

endmodule : bprs_top

// File: bprs_top_sva.sv
module bprs_top_sva #(
    parameter int CYC_10MS = 20,
    parameter int CYC_5MS = 10,
    parameter int CYC_1MS = 4,
    parameter int BOOT_W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // inputs of the sequencer
    input wire bprs_pkg::bprs_pg_t pg_in,
    input wire logic [BOOT_W-1:0] boot_cfg_in,
    // outputs of the sequencer
    input wire bprs_pkg::bprs_en_t rail_en,
    input wire bprs_pkg::bprs_cpu_t cpu_out,
    input wire logic [BOOT_W-1:0] boot_pin_out,
    input wire logic boot_pin_oe_n,
    input wire logic system_power_good
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int W5_LO = CYC_5MS - 1;
    localparam int W5_HI = CYC_5MS + 4;
    localparam int W1_LO = CYC_1MS - 1;
    localparam int W1_HI = CYC_1MS + 4;
    localparam int D5_LO = CYC_5MS - 8;
    localparam int D5_HI = CYC_5MS + 2;
    logic [15:0] c_aux, c_mid, c_core, c_io, c_ddr, c_term, c_clk, c_warm, c_por, c_full;

    // cycles a level has been high without a break
    function automatic logic [15:0] bump(input logic [15:0] c, input logic on);
        return on ? c + {15'h0000, c != 16'hffff} : 16'h0000;
    endfunction : bump

    always_ff @(posedge ref_clk) begin
        c_aux <= bump(c_aux, pg_in.aux_3v3_rail);
        c_mid <= bump(c_mid, pg_in.mezz_5v_rail & pg_in.rail_2v5);
        c_core <= bump(c_core, pg_in.avs_core_rail & pg_in.fixed_core_rail);
        c_io <= bump(c_io, pg_in.io_1v8_rail);
        c_ddr <= bump(c_ddr, pg_in.ddr_1v5_rail);
        c_term <= bump(c_term, pg_in.ddr_term_0v75_rail & pg_in.pll_lock);
        c_clk <= bump(c_clk, cpu_out.clkgen_power_down_n);
        c_warm <= bump(c_warm, cpu_out.warm_reset_n);
        c_por <= bump(c_por, cpu_out.power_on_reset_n);
        c_full <= bump(c_full, cpu_out.full_reset_n);
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_resets_hit;
        $fell(cpu_out.full_reset_n) && cpu_out.clkgen_power_down_n;
    endsequence
    sequence s_clocks_stop;
        cpu_out.clkgen_power_down_n [*4] ##[D5_LO:D5_HI]
            (!cpu_out.clkgen_power_down_n && !cpu_out.out_1v8_unlock);
    endsequence
    sequence s_rails_off;
        ##[0:2] (rail_en == '0 && !cpu_out.mux_power_down_n && !cpu_out.mux_output_enable);
    endsequence

    a_locked_until_io: assert property (!rail_en.io_1v8_rail |-> cpu_out == '0)
        else $error("processor outputs active before io rail");
    a_mid_after_aux: assert property ($rose(rail_en.mezz_5v_rail) |-> c_aux >= CYC_10MS && rail_en.rail_2v5)
        else $error("5V and 2.5V enabled early");
    a_core_after_mid: assert property ($rose(rail_en.avs_core_rail) |-> c_mid >= CYC_5MS)
        else $error("core rail enabled early");
    a_io_after_core: assert property ($rose(rail_en.io_1v8_rail) |-> c_core >= CYC_5MS)
        else $error("io rail enabled early");
    a_clk_after_io: assert property ($rose(cpu_out.clkgen_power_down_n) |-> c_io >= CYC_5MS && cpu_out.out_1v8_unlock)
        else $error("clock generator started early");
    a_ddr_after_clk: assert property ($rose(rail_en.ddr_1v5_rail) |-> c_clk inside {[W5_LO:W5_HI]})
        else $error("ddr rail enable off time");
    a_term_after_ddr: assert property ($rose(rail_en.ddr_term_0v75_rail) |-> c_ddr >= CYC_5MS)
        else $error("termination rail enabled early");
    a_mux_pd_follow: assert property ($rose(pg_in.ddr_1v5_rail) && rail_en.ddr_1v5_rail |-> ##[1:4] cpu_out.mux_power_down_n)
        else $error("mux power-down not released");
    a_mux_oe_follow: assert property ($rose(pg_in.ddr_term_0v75_rail) && rail_en.ddr_term_0v75_rail |-> ##[1:4] cpu_out.mux_output_enable)
        else $error("mux output enable missing");
    a_warm_after_term: assert property ($rose(cpu_out.warm_reset_n) |-> c_term >= CYC_5MS && cpu_out.other_unlock)
        else $error("warm reset released early");
    a_boot_driven: assert property ($rose(cpu_out.warm_reset_n) |-> !boot_pin_oe_n && boot_pin_out == boot_cfg_in)
        else $error("boot pins not driven");
    a_por_after_warm: assert property ($rose(cpu_out.power_on_reset_n) |-> c_warm inside {[W5_LO:W5_HI]})
        else $error("power-on reset release off time");
    a_full_after_por: assert property ($rose(cpu_out.full_reset_n) |-> c_por inside {[W5_LO:W5_HI]})
        else $error("full reset release off time");
    a_boot_release: assert property ($fell(cpu_out.boot_drive) && cpu_out.full_reset_n |-> c_full inside {[W1_LO:W1_HI]} && boot_pin_oe_n)
        else $error("boot pins release off time");
    a_fail_resets: assert property ($fell(pg_in.payload_12v_rail) && cpu_out.full_reset_n |-> ##[1:4] (!cpu_out.full_reset_n && !cpu_out.power_on_reset_n))
        else $error("resets not asserted on payload loss");
    a_fail_clocks: assert property (s_resets_hit |-> s_clocks_stop)
        else $error("clocks not stopped after resets");
    a_fail_rails: assert property ($fell(cpu_out.clkgen_power_down_n) |-> s_rails_off)
        else $error("rails not removed after clocks");
    a_sys_good: assert property (!(&pg_in[9:1]) [*4] |-> !system_power_good)
        else $error("system power good without all rails");
    a_rail_loss: assert property ($fell(pg_in.io_1v8_rail) && rail_en.io_1v8_rail && cpu_out.full_reset_n |-> ##[1:4] !cpu_out.full_reset_n)
        else $error("no shutdown on rail loss");

endmodule : bprs_top_sva

bind bprs_top bprs_top_sva #(.CYC_10MS(CYC_10MS), .CYC_5MS(CYC_5MS), .CYC_1MS(CYC_1MS), .BOOT_W(BOOT_W))
    u_sva (.ref_clk(ref_clk), .rst_b(rst_b), .pg_in(pg_in), .boot_cfg_in(boot_cfg_in),
    .rail_en(rail_en), .cpu_out(cpu_out), .boot_pin_out(boot_pin_out),
    .boot_pin_oe_n(boot_pin_oe_n), .system_power_good(system_power_good));

// File: bprs_rails_model.sv
module bprs_rails_model #(
    parameter int FIX_DLY = 10
) (
    // clock
    input wire logic ref_clk,
    // stimulus controls
    input wire logic payload_on,
    input wire logic slow,
    input wire bprs_pkg::bprs_pg_t kill,
    // sequencer outputs
    input wire bprs_pkg::bprs_en_t rail_en,
    input wire bprs_pkg::bprs_cpu_t cpu_out,
    // power-good and lock back to the sequencer
    output bprs_pkg::bprs_pg_t pg
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] req;
    logic avs_good;
    logic [7:0] cnt [10];
    int dly;

    assign dly = slow ? 9 : 3;
    // avs good worked out apart from pg so that req does not loop through pg
    assign avs_good = rail_en.avs_core_rail && !kill.avs_core_rail && int'(cnt[5]) >= dly;
    // fixed core comes up on the controller's own delay after avs core is good
    assign req = {payload_on, payload_on, rail_en.mezz_5v_rail, rail_en.rail_2v5,
        rail_en.avs_core_rail, rail_en.fixed_core_rail & avs_good, rail_en.io_1v8_rail,
        rail_en.ddr_1v5_rail, rail_en.ddr_term_0v75_rail, cpu_out.clkgen_power_down_n};

    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < 10; i++) begin
            cnt[i] <= req[i] ? cnt[i] + {7'h00, cnt[i] != 8'hff} : 8'h00;
        end
    end

    // good only once the rail has settled, dropped at once on removal
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            pg[i] = req[i] && !kill[i] && int'(cnt[i]) >= ((i == 4) ? FIX_DLY : dly);
        end
    end
endmodule : bprs_rails_model

// File: bprs_top_tb_top.sv
module bprs_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic payload_on = 1'b0;
    logic slow = 1'b0;
    bprs_pkg::bprs_pg_t kill = '0;
    bprs_pkg::bprs_pg_t pg_in;
    logic [15:0] boot_cfg_in = 16'h0000;
    bprs_pkg::bprs_en_t rail_en;
    bprs_pkg::bprs_cpu_t cpu_out;
    logic [15:0] boot_pin_out;
    logic boot_pin_oe_n;
    logic system_power_good;
    logic [15:0] seen = 16'h0000;
    logic [15:0] want;
    logic [15:0] exp_q [$];
    // {rail_en, cpu_out} after each step of power-up then shutdown
    logic [15:0] tbl [15] = '{16'hc000, 16'hf000, 16'hf800, 16'hf980, 16'hfd80, 16'hfdc0,
        16'hffc0, 16'hffe0, 16'hfff9, 16'hfffd, 16'hffff, 16'hfffe, 16'hfff8, 16'hfe60, 16'h0000};
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;

    bprs_top #(.CYC_10MS(20), .CYC_5MS(10), .CYC_1MS(4), .BOOT_W(16)) uut (
        .ref_clk(ref_clk), .rst_b(rst_b), .pg_in(pg_in), .boot_cfg_in(boot_cfg_in),
        .rail_en(rail_en), .cpu_out(cpu_out), .boot_pin_out(boot_pin_out),
        .boot_pin_oe_n(boot_pin_oe_n), .system_power_good(system_power_good));

    bprs_rails_model #(.FIX_DLY(10)) u_model (
        .ref_clk(ref_clk), .payload_on(payload_on), .slow(slow), .kill(kill),
        .rail_en(rail_en), .cpu_out(cpu_out), .pg(pg_in));

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic complete_run();
        if (exp_q.size() != 0) begin
            err_count++;
        end
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic expect_cycle();
        for (int i = 0; i < 15; i++) begin
            exp_q.push_back(tbl[i]);
        end
    endtask : expect_cycle

    // every change of the outputs is one step of the sequence
    always @(negedge ref_clk) begin
        if ({rail_en, cpu_out} !== seen) begin
            seen = {rail_en, cpu_out};
            want = (exp_q.size() > 0) ? exp_q.pop_front() : ~seen;
            n_compared++;
            if (want !== seen) begin
                err_count++;
                $display("BAD t=%0t exp %h got %h", $time, want, seen);
            end
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            $display("BAD t=%0t timeout exp %h got %h", $time, 16'h0001, 16'h0000);
            complete_run();
        end
    end

    initial begin
        void'($urandom(85));
        repeat (8) @(negedge ref_clk);
        rst_b = 1'b1;
        // prompt rails, 5V good glitches inside its stability window
        boot_cfg_in = 16'($urandom);
        expect_cycle();
        payload_on = 1'b1;
        @(negedge ref_clk iff (pg_in.mezz_5v_rail === 1'b1));
        repeat (3) @(negedge ref_clk);
        kill.mezz_5v_rail = 1'b1;
        repeat ($urandom_range(1, 3)) @(negedge ref_clk);
        kill.mezz_5v_rail = 1'b0;
        // payload lost while running
        @(negedge ref_clk iff (system_power_good === 1'b1));
        repeat (5) @(negedge ref_clk);
        payload_on = 1'b0;
        @(negedge ref_clk iff (rail_en === '0));
        repeat (5) @(negedge ref_clk);
        // slow rails, io rail lost while running
        slow = 1'b1;
        boot_cfg_in = 16'($urandom);
        expect_cycle();
        payload_on = 1'b1;
        @(negedge ref_clk iff (system_power_good === 1'b1));
        kill.io_1v8_rail = 1'b1;
        @(negedge ref_clk iff (rail_en === '0));
        payload_on = 1'b0;
        kill = '0;
        repeat (20) @(negedge ref_clk);
        complete_run();
    end
endmodule : bprs_top_tb_top
